// *** bench/drive_speed_command_select_bench.sv ***
module drive_speed_command_select_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rdata, freq;
   logic rev, led, sblink;
   drive_cmd_pkg::start_req_t st = '0;
   drive_cmd_pkg::speed_sel_t sel = '0;
   drive_cmd_pkg::start_req_t st_pin;
   drive_cmd_pkg::speed_sel_t sel_pin;
   logic [9:0] vin = 10'h000;
   logic [9:0] cin = 10'h000;
   logic [9:0] v_pin, c_pin;
   int n_fail = 0;
   int comparisons = 0;
   int hi, rs;
   always #2 clk = ~clk;
   operator_switch_model operator_switch_model_inst (.clk(clk), .start_cmd(st), .sel_cmd(sel),
      .volt_cmd(vin), .cur_cmd(cin), .start_pin(st_pin), .sel_pin(sel_pin), .volt_pin(v_pin),
      .cur_pin(c_pin));
   drive_speed_command_select #(.TICK_CYC(4)) drive_speed_command_select_inst (.CLK(clk),
      .RESETN(resetn), .FWD_START_IN(st_pin.fwd), .REV_START_IN(st_pin.rev),
      .NET_INPUT_ZERO(1'b0), .NET_INPUT_ONE(1'b0), .SPEED_HIGH_SEL(sel_pin.high),
      .SPEED_MID_SEL(sel_pin.mid), .SPEED_LOW_SEL(sel_pin.low), .SPEED_EXT_SEL(sel_pin.ext),
      .VOLT_IN(v_pin), .CUR_IN(c_pin), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .OUT_FREQ(freq), .OUT_REV(rev), .RUN_INDICATOR(led), .SETTING_BLINK(sblink));
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wreg(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [5:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdata, exp);
   endtask : rreg
   task automatic sw(input logic [2:0] s, input logic [3:0] q, input logic [9:0] v,
                     input logic [9:0] c);
      @(posedge clk);
      st <= drive_cmd_pkg::start_req_t'(s);
      sel <= drive_cmd_pkg::speed_sel_t'(q);
      vin <= v;
      cin <= c;
      repeat (4) @(posedge clk);
   endtask : sw
   task automatic wfreq(input logic [15:0] exp, input int lim);
      for (int i = 0; i < lim && freq !== exp; i++)
         @(negedge clk);
      chk(freq, exp);
   endtask : wfreq
   // counts high cycles and rising edges of the indicator or the setting blink
   task automatic watch(input int n, input bit which);
      logic p, x;
      hi = 0;
      rs = 0;
      p = which ? sblink : led;
      repeat (n)
      begin
         @(negedge clk);
         x = which ? sblink : led;
         hi += int'(x === 1'b1);
         rs += int'(x === 1'b1 && p !== 1'b1);
         p = x;
      end
   endtask : watch
   initial
   begin
      #200000;
      n_fail++;
      finish_test();
   end
   initial
   begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      rreg(6'h00, 16'h1770);
      rreg(6'h01, 16'h0BB8);
      rreg(6'h02, 16'h03E8);
      rreg(6'h16, 16'h003C);
      rreg(6'h17, 16'h003D);
      rreg(6'h3F, 16'h0000);
      wreg(6'h19, 16'h0002);
      wreg(6'h10, 16'h0000);
      wreg(6'h11, 16'h0000);
      wreg(6'h1A, 16'h0000);
      for (int k = 0; k < 8; k++)
      begin
         sw(3'b000, 4'(k), 10'h000, 10'h000);
         rreg(6'h21, k[0] ? 16'h03E8 : k[1] ? 16'h0BB8 : k[2] ? 16'h1770 : 16'h0000);
      end
      sw(3'b100, 4'b0100, 10'h000, 10'h000);
      wfreq(16'h1770, 50);
      watch(1000, 1'b0);
      chk(16'(hi), 16'h03E8);
      sw(3'b110, 4'b0100, 10'h000, 10'h000);
      wfreq(16'h0000, 50);
      rreg(6'h22, 16'h0008);
      repeat (20) @(negedge clk);
      chk(freq, 16'h0000);
      sw(3'b000, 4'b0100, 10'h000, 10'h000);
      watch(100, 1'b0);
      chk(16'(hi), 16'h0000);
      sw(3'b010, 4'b0100, 10'h000, 10'h000);
      wfreq(16'h1770, 50);
      chk(16'(rev), 16'h0001);
      watch(4000, 1'b0);
      chk(16'(hi > 1500 && hi < 2500 && rs >= 1 && rs <= 2), 16'h0001);
      sw(3'b000, 4'b0000, 10'h000, 10'h000);
      wfreq(16'h0000, 50);
      sw(3'b100, 4'b0000, 10'h000, 10'h000);
      watch(4000, 1'b0);
      chk(16'(hi > 1500 && hi < 2500 && rs >= 3 && rs <= 5), 16'h0001);
      wreg(6'h1A, 16'h0001);
      sw(3'b000, 4'b0000, 10'h3FF, 10'h000);
      rreg(6'h21, 16'h1770);
      wreg(6'h12, 16'h1388);
      rreg(6'h21, 16'h1388);
      sw(3'b000, 4'b0000, 10'h200, 10'h000);
      rreg(6'h21, 16'h09C6);
      wreg(6'h18, 16'h0004);
      sw(3'b001, 4'b0000, 10'h000, 10'h3FF);
      rreg(6'h21, 16'h1770);
      rreg(6'h22, 16'h0004);
      sw(3'b001, 4'b0000, 10'h000, 10'h0CD);
      rreg(6'h21, 16'h0000);
      wreg(6'h14, 16'h1388);
      sw(3'b001, 4'b0000, 10'h000, 10'h3FF);
      rreg(6'h21, 16'h1388);
      wreg(6'h18, 16'h0000);
      wreg(6'h1A, 16'h0000);
      // 2.0 s for the full ramp: 2000 ticks of 4 cycles, halfway after about 4000 cycles
      wreg(6'h10, 16'h0014);
      wreg(6'h11, 16'h0014);
      sw(3'b100, 4'b0100, 10'h000, 10'h000);
      repeat (4000) @(negedge clk);
      chk(16'(freq > 16'h0900 && freq < 16'h0F00), 16'h0001);
      wfreq(16'h1770, 5000);
      sw(3'b000, 4'b0100, 10'h000, 10'h000);
      repeat (4000) @(negedge clk);
      chk(16'(freq > 16'h0900 && freq < 16'h0F00), 16'h0001);
      wfreq(16'h0000, 5000);
      wreg(6'h1A, 16'h0002);
      wreg(6'h0E, 16'h0123);
      sw(3'b000, 4'b1111, 10'h000, 10'h000);
      rreg(6'h21, 16'h0123);
      sw(3'b000, 4'b0100, 10'h000, 10'h000);
      rreg(6'h21, 16'h1770);
      watch(1000, 1'b1);
      chk(16'(hi > 300 && hi < 700), 16'h0001);
      finish_test();
   end
endmodule : drive_speed_command_select_bench

// *** bench/operator_switch_model.sv ***
module operator_switch_model (
   input wire logic clk,
   input wire drive_cmd_pkg::start_req_t start_cmd,
   input wire drive_cmd_pkg::speed_sel_t sel_cmd,
   input wire logic [9:0] volt_cmd,
   input wire logic [9:0] cur_cmd,
   output drive_cmd_pkg::start_req_t start_pin,
   output drive_cmd_pkg::speed_sel_t sel_pin,
   output logic [9:0] volt_pin,
   output logic [9:0] cur_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // switches and sources settle one clock after the operator moves them
   always @(posedge clk)
   begin
      start_pin <= start_cmd;
      // current select switch is wired to the low-speed terminal
      sel_pin <= '{ext: sel_cmd.ext, high: sel_cmd.high, mid: sel_cmd.mid,
                   low: sel_cmd.low | start_cmd.cur_sel};
      volt_pin <= volt_cmd;
      cur_pin <= cur_cmd;
   end
endmodule : operator_switch_model

// *** rtl/drive_cmd_pkg.sv ***
package drive_cmd_pkg;
   // clock and time base
   localparam int CLK_PERIOD_NS = 4;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int SLOW_BLINK_MS = 1000;
   localparam int SLOW_BLINK_ON_MS = 500;
   localparam int FAST_BLINK_MS = 250;
   localparam int FAST_BLINK_ON_MS = 125;
   localparam int ACK_BLINK_MS = 3000;
   // widths
   localparam int FREQ_W = 16;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 16;
   localparam int ADC_W = 10;
   localparam int RATE_W = 24;
   // frequency unit is 0.01 Hz, time unit is 0.1 s
   localparam logic [15:0] REF_FREQ = 16'h1770;
   localparam logic [15:0] HIGH_FREQ_G1 = 16'h1770;
   localparam logic [15:0] HIGH_FREQ_G2 = 16'h1388;
   localparam logic [15:0] MID_FREQ_RST = 16'h0BB8;
   localparam logic [15:0] LOW_FREQ_RST = 16'h03E8;
   localparam logic [15:0] OTHER_PRESET_RST = 16'h0000;
   localparam logic [15:0] ACCEL_RST = 16'h0032;
   localparam logic [15:0] DECEL_RST = 16'h0032;
   localparam logic [15:0] GAIN_RST = 16'h1770;
   localparam logic [15:0] BIAS_RST = 16'h0000;
   localparam logic [15:0] TIME_TO_MS = 16'h0064;
   // analog codes: full scale is 5 V or 20 mA, 4 mA is the current zero point
   localparam logic [9:0] ADC_FULL = 10'h3FF;
   localparam logic [9:0] CUR_ZERO_CODE = 10'h0CD;
   // input terminal function codes
   localparam logic [7:0] FUNC_LOW_SPEED = 8'h00;
   localparam logic [7:0] FUNC_CUR_SEL = 8'h04;
   localparam logic [7:0] FUNC_FWD_START = 8'h3C;
   localparam logic [7:0] FUNC_REV_START = 8'h3D;
   localparam logic [7:0] OPMODE_RST = 8'h00;
   // register map
   localparam logic [5:0] PRESET_BASE = 6'h00;
   localparam logic [5:0] PRESET_LAST = 6'h0E;
   localparam logic [5:0] ACCEL_ADDR = 6'h10;
   localparam logic [5:0] DECEL_ADDR = 6'h11;
   localparam logic [5:0] VGAIN_ADDR = 6'h12;
   localparam logic [5:0] VBIAS_ADDR = 6'h13;
   localparam logic [5:0] CGAIN_ADDR = 6'h14;
   localparam logic [5:0] CBIAS_ADDR = 6'h15;
   localparam logic [5:0] FSEL0_ADDR = 6'h16;
   localparam logic [5:0] FSEL1_ADDR = 6'h17;
   localparam logic [5:0] FSELL_ADDR = 6'h18;
   localparam logic [5:0] OPMODE_ADDR = 6'h19;
   localparam logic [5:0] CTRL_ADDR = 6'h1A;
   localparam logic [5:0] FREQ_ADDR = 6'h20;
   localparam logic [5:0] CMD_ADDR = 6'h21;
   localparam logic [5:0] STAT_ADDR = 6'h22;
   // control bits: 0 voltage reference enable, 1 fifteen-speed combination mode
   localparam int CTRL_VREF_BIT = 0;
   localparam int CTRL_COMBO_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h1;

   typedef enum logic [1:0] {
      RUN_STOP = 2'b00,
      RUN_FWD = 2'b01,
      RUN_REV = 2'b10
   } run_state_t;

   typedef struct packed {
      logic ext;
      logic high;
      logic mid;
      logic low;
   } speed_sel_t;

   typedef struct packed {
      logic fwd;
      logic rev;
      logic cur_sel;
   } start_req_t;
endpackage : drive_cmd_pkg

// *** rtl/drive_speed_command_select.sv ***
// What this block does
// - both start inputs asserted while stopped: rotation does not begin
// - both start inputs asserted while running: ramp down to a stop
// - preset defaults 60 Hz (50 Hz group two), 30 Hz, 10 Hz; each settable
// - by default several speed selects together give the lowest speed preset
// - select combinations address up to fifteen preset speeds
// - with start and nonzero command, frequency rises at acceleration rate then holds
// - start removed or command zero: frequency falls at deceleration rate to zero
// - run indicator lit in forward rotation, slow blink in reverse
// - start asserted with zero command: run indicator blinks
// - start removed and motor stopped: run indicator off
// - function code 60 is forward start, 61 reverse start; these are defaults
// - function code 4 selects current input as the frequency reference
// - default current scaling: 20 mA gives 60 Hz, 4 mA or less gives 0 Hz
// - 5 V commands the voltage gain frequency, default 60 Hz
// - 20 mA commands the current gain frequency setting
// - network variant has two inputs, assigned via the two first function selects
// - a write to a setting register is stored; any write flashes the setting blink output for 3 s as acknowledge
module drive_speed_command_select #(
   parameter int TICK_CYC = drive_cmd_pkg::TICK_CYCLES,
   parameter bit GROUP_TWO = 1'b0,
   parameter bit NET_VARIANT = 1'b0
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic FWD_START_IN,
   input wire logic REV_START_IN,
   input wire logic NET_INPUT_ZERO,
   input wire logic NET_INPUT_ONE,
   input wire logic SPEED_HIGH_SEL,
   input wire logic SPEED_MID_SEL,
   input wire logic SPEED_LOW_SEL,
   input wire logic SPEED_EXT_SEL,
   input wire logic [drive_cmd_pkg::ADC_W-1:0] VOLT_IN,
   input wire logic [drive_cmd_pkg::ADC_W-1:0] CUR_IN,
   input wire logic [drive_cmd_pkg::ADDR_W-1:0] ADDR,
   input wire logic [drive_cmd_pkg::DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [drive_cmd_pkg::DATA_W-1:0] RDATA,
   output logic [drive_cmd_pkg::FREQ_W-1:0] OUT_FREQ,
   output logic OUT_REV,
   output logic RUN_INDICATOR,
   output logic SETTING_BLINK
);

   logic [15:0] preset_mem [0:14];
   logic [15:0] accel_time_setting;
   logic [15:0] decel_time_setting;
   logic [15:0] voltage_gain_freq;
   logic [15:0] voltage_bias_freq;
   logic [15:0] current_gain_freq;
   logic [15:0] current_bias_freq;
   logic [7:0] first_input_func_sel;
   logic [7:0] second_input_func_sel;
   logic [7:0] low_sel_input_func_sel;
   logic [7:0] operation_mode_setting;
   logic [1:0] ctrl_reg;
   drive_cmd_pkg::run_state_t state_reg;
   logic [15:0] freq_reg;
   logic [23:0] acc_reg;
   logic [31:0] tick_cnt_reg;
   logic tick;
   logic [9:0] blink_ms_reg;
   logic [11:0] ack_ms_reg;
   drive_cmd_pkg::speed_sel_t sel;
   drive_cmd_pkg::start_req_t req;
   logic [15:0] cmd_freq;
   logic [15:0] target;
   logic [23:0] rate;
   logic fwd_only;
   logic rev_only;
   logic run_req;
   logic slow_on;
   logic fast_on;

   // linear map of an analog code between bias (at lo) and gain (at full scale)
   function automatic logic [15:0] scale(input logic [9:0] code, input logic [9:0] lo,
                                         input logic [15:0] bias, input logic [15:0] gain);
      logic [9:0] span;
      logic [9:0] pos;
      logic signed [17:0] diff;
      logic signed [29:0] prod;
      logic signed [17:0] res;
      span = drive_cmd_pkg::ADC_FULL - lo;
      pos = (code > lo) ? code - lo : 10'h000;
      diff = $signed({2'b00, gain}) - $signed({2'b00, bias});
      prod = diff * $signed({2'b00, pos});
      res = $signed({2'b00, bias}) + 18'(prod / $signed({20'h00000, span}));
      scale = res[15:0];
   endfunction : scale

   // true when a terminal carrying the given function is asserted
   function automatic logic has_func(input logic [7:0] fc, input logic t0, input logic t1,
                                     input logic tl, input logic [7:0] f0,
                                     input logic [7:0] f1, input logic [7:0] fl);
      has_func = (t0 && f0 == fc) || (t1 && f1 == fc) || (tl && fl == fc);
   endfunction : has_func

   // terminal decode; the network variant has only its two digital inputs
   always_comb
   begin
      logic t0;
      logic t1;
      logic tl;
      t0 = NET_VARIANT ? NET_INPUT_ZERO : FWD_START_IN;
      t1 = NET_VARIANT ? NET_INPUT_ONE : REV_START_IN;
      tl = NET_VARIANT ? 1'b0 : SPEED_LOW_SEL;
      req.fwd = has_func(drive_cmd_pkg::FUNC_FWD_START, t0, t1, tl, first_input_func_sel,
                         second_input_func_sel, low_sel_input_func_sel);
      req.rev = has_func(drive_cmd_pkg::FUNC_REV_START, t0, t1, tl, first_input_func_sel,
                         second_input_func_sel, low_sel_input_func_sel);
      req.cur_sel = has_func(drive_cmd_pkg::FUNC_CUR_SEL, t0, t1, tl, first_input_func_sel,
                             second_input_func_sel, low_sel_input_func_sel);
      sel.low = has_func(drive_cmd_pkg::FUNC_LOW_SPEED, t0, t1, tl, first_input_func_sel,
                         second_input_func_sel, low_sel_input_func_sel);
      sel.mid = SPEED_MID_SEL && !NET_VARIANT;
      sel.high = SPEED_HIGH_SEL && !NET_VARIANT;
      sel.ext = SPEED_EXT_SEL && !NET_VARIANT;
   end

   // frequency command selection: presets first, then current, then voltage
   always_comb
   begin
      logic [3:0] idx;
      idx = {sel.ext, sel.low, sel.mid, sel.high};
      if (ctrl_reg[drive_cmd_pkg::CTRL_COMBO_BIT] && idx != 4'h0)
         cmd_freq = preset_mem[idx - 4'h1];
      else if (sel.low)
         cmd_freq = preset_mem[2];
      else if (sel.mid)
         cmd_freq = preset_mem[1];
      else if (sel.high)
         cmd_freq = preset_mem[0];
      else if (req.cur_sel)
         cmd_freq = scale(CUR_IN, drive_cmd_pkg::CUR_ZERO_CODE, current_bias_freq,
                          current_gain_freq);
      else if (ctrl_reg[drive_cmd_pkg::CTRL_VREF_BIT])
         cmd_freq = scale(VOLT_IN, 10'h000, voltage_bias_freq,
                          voltage_gain_freq);
      else
         cmd_freq = 16'h0000;
   end

   assign fwd_only = req.fwd && !req.rev;
   assign rev_only = req.rev && !req.fwd;
   assign run_req = (state_reg == drive_cmd_pkg::RUN_FWD) ? fwd_only :
                    (state_reg == drive_cmd_pkg::RUN_REV) ? rev_only : 1'b0;
   assign target = run_req ? cmd_freq : 16'h0000;
   assign rate = (freq_reg < target) ?
                 24'(accel_time_setting) * 24'(drive_cmd_pkg::TIME_TO_MS) :
                 24'(decel_time_setting) * 24'(drive_cmd_pkg::TIME_TO_MS);

   // millisecond tick
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         tick_cnt_reg <= 32'h00000000;
      else if (tick_cnt_reg >= 32'(TICK_CYC - 1))
         tick_cnt_reg <= 32'h00000000;
      else
         tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
   end
   assign tick = (tick_cnt_reg >= 32'(TICK_CYC - 1));

   // register writes
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         for (int i = 0; i < 15; i++)
            preset_mem[i] <= drive_cmd_pkg::OTHER_PRESET_RST;
         preset_mem[0] <= GROUP_TWO ? drive_cmd_pkg::HIGH_FREQ_G2 :
                          drive_cmd_pkg::HIGH_FREQ_G1;
         preset_mem[1] <= drive_cmd_pkg::MID_FREQ_RST;
         preset_mem[2] <= drive_cmd_pkg::LOW_FREQ_RST;
         accel_time_setting <= drive_cmd_pkg::ACCEL_RST;
         decel_time_setting <= drive_cmd_pkg::DECEL_RST;
         voltage_gain_freq <= drive_cmd_pkg::GAIN_RST;
         voltage_bias_freq <= drive_cmd_pkg::BIAS_RST;
         current_gain_freq <= drive_cmd_pkg::GAIN_RST;
         current_bias_freq <= drive_cmd_pkg::BIAS_RST;
         first_input_func_sel <= drive_cmd_pkg::FUNC_FWD_START;
         second_input_func_sel <= drive_cmd_pkg::FUNC_REV_START;
         low_sel_input_func_sel <= drive_cmd_pkg::FUNC_LOW_SPEED;
         operation_mode_setting <= drive_cmd_pkg::OPMODE_RST;
         ctrl_reg <= drive_cmd_pkg::CTRL_RST;
      end
      else if (WR)
      begin
         if (ADDR <= drive_cmd_pkg::PRESET_LAST)
            preset_mem[4'(ADDR)] <= WDATA;
         case (ADDR)
            drive_cmd_pkg::ACCEL_ADDR: accel_time_setting <= WDATA;
            drive_cmd_pkg::DECEL_ADDR: decel_time_setting <= WDATA;
            drive_cmd_pkg::VGAIN_ADDR: voltage_gain_freq <= WDATA;
            drive_cmd_pkg::VBIAS_ADDR: voltage_bias_freq <= WDATA;
            drive_cmd_pkg::CGAIN_ADDR: current_gain_freq <= WDATA;
            drive_cmd_pkg::CBIAS_ADDR: current_bias_freq <= WDATA;
            drive_cmd_pkg::FSEL0_ADDR: first_input_func_sel <= WDATA[7:0];
            drive_cmd_pkg::FSEL1_ADDR: second_input_func_sel <= WDATA[7:0];
            drive_cmd_pkg::FSELL_ADDR: low_sel_input_func_sel <= WDATA[7:0];
            drive_cmd_pkg::OPMODE_ADDR: operation_mode_setting <= WDATA[7:0];
            drive_cmd_pkg::CTRL_ADDR: ctrl_reg <= WDATA[1:0];
            default: ;
         endcase
      end
   end

   // register reads, data in the following cycle
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         RDATA <= 16'h0000;
      else if (RD)
      begin
         if (ADDR <= drive_cmd_pkg::PRESET_LAST)
            RDATA <= preset_mem[4'(ADDR)];
         else
            case (ADDR)
               drive_cmd_pkg::ACCEL_ADDR: RDATA <= accel_time_setting;
               drive_cmd_pkg::DECEL_ADDR: RDATA <= decel_time_setting;
               drive_cmd_pkg::VGAIN_ADDR: RDATA <= voltage_gain_freq;
               drive_cmd_pkg::VBIAS_ADDR: RDATA <= voltage_bias_freq;
               drive_cmd_pkg::CGAIN_ADDR: RDATA <= current_gain_freq;
               drive_cmd_pkg::CBIAS_ADDR: RDATA <= current_bias_freq;
               drive_cmd_pkg::FSEL0_ADDR: RDATA <= {8'h00, first_input_func_sel};
               drive_cmd_pkg::FSEL1_ADDR: RDATA <= {8'h00, second_input_func_sel};
               drive_cmd_pkg::FSELL_ADDR: RDATA <= {8'h00, low_sel_input_func_sel};
               drive_cmd_pkg::OPMODE_ADDR: RDATA <= {8'h00, operation_mode_setting};
               drive_cmd_pkg::CTRL_ADDR: RDATA <= {14'h0000, ctrl_reg};
               drive_cmd_pkg::FREQ_ADDR: RDATA <= freq_reg;
               drive_cmd_pkg::CMD_ADDR: RDATA <= cmd_freq;
               drive_cmd_pkg::STAT_ADDR: RDATA <= {12'h000, req.fwd && req.rev, req.cur_sel,
                                                   state_reg};
               default: RDATA <= 16'h0000;
            endcase
      end
   end

   // rotation state
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         state_reg <= drive_cmd_pkg::RUN_STOP;
      else
         case (state_reg)
            drive_cmd_pkg::RUN_STOP:
               if (fwd_only)
                  state_reg <= drive_cmd_pkg::RUN_FWD;
               else if (rev_only)
                  state_reg <= drive_cmd_pkg::RUN_REV;
            drive_cmd_pkg::RUN_FWD, drive_cmd_pkg::RUN_REV:
               if (!run_req && freq_reg == 16'h0000)
                  state_reg <= drive_cmd_pkg::RUN_STOP;
            default: state_reg <= drive_cmd_pkg::RUN_STOP;
         endcase
   end

   // ramp: each tick adds the reference frequency, each cycle spends one rate step
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         freq_reg <= 16'h0000;
         acc_reg <= 24'h000000;
      end
      else if (freq_reg == target)
         acc_reg <= 24'h000000;
      else if (rate == 24'h000000)
         freq_reg <= target;
      else if (acc_reg >= rate)
      begin
         acc_reg <= acc_reg - rate;
         if (freq_reg < target)
            freq_reg <= freq_reg + 16'h0001;
         else
            freq_reg <= freq_reg - 16'h0001;
      end
      else if (tick)
         acc_reg <= acc_reg + {8'h00, drive_cmd_pkg::REF_FREQ};
   end

   // blink time base and acknowledge window
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         blink_ms_reg <= 10'h000;
      else if (tick)
         blink_ms_reg <= (blink_ms_reg >= 10'(drive_cmd_pkg::SLOW_BLINK_MS - 1)) ?
                         10'h000 : blink_ms_reg + 10'h001;
   end
   assign slow_on = blink_ms_reg < 10'(drive_cmd_pkg::SLOW_BLINK_ON_MS);
   assign fast_on = (blink_ms_reg % 10'(drive_cmd_pkg::FAST_BLINK_MS)) <
                    10'(drive_cmd_pkg::FAST_BLINK_ON_MS);

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         ack_ms_reg <= 12'h000;
      else if (WR)
         ack_ms_reg <= 12'(drive_cmd_pkg::ACK_BLINK_MS);
      else if (tick && ack_ms_reg != 12'h000)
         ack_ms_reg <= ack_ms_reg - 12'h001;
   end

   // outputs
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         RUN_INDICATOR <= 1'b0;
         SETTING_BLINK <= 1'b0;
         OUT_FREQ <= 16'h0000;
         OUT_REV <= 1'b0;
      end
      else
      begin
         OUT_FREQ <= freq_reg;
         OUT_REV <= (state_reg == drive_cmd_pkg::RUN_REV);
         SETTING_BLINK <= (ack_ms_reg != 12'h000) && fast_on;
         case (state_reg)
            drive_cmd_pkg::RUN_FWD:
               RUN_INDICATOR <= (run_req && cmd_freq == 16'h0000) ? fast_on : 1'b1;
            drive_cmd_pkg::RUN_REV:
               RUN_INDICATOR <= (run_req && cmd_freq == 16'h0000) ? fast_on :
                                slow_on;
            default: RUN_INDICATOR <= 1'b0;
         endcase
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);

   AST_BOTH_NO_START: assert property (
      state_reg == drive_cmd_pkg::RUN_STOP && req.fwd && req.rev
      |=> state_reg == drive_cmd_pkg::RUN_STOP)
      else $error("started with both start inputs asserted");
   AST_BOTH_DECEL: assert property (
      state_reg != drive_cmd_pkg::RUN_STOP && req.fwd && req.rev && freq_reg != 16'h0000
      && rate != 24'h000000 |=> freq_reg <= $past(freq_reg))
      else $error("frequency rose with both start inputs asserted");
   AST_LOW_PRIORITY: assert property (
      !ctrl_reg[drive_cmd_pkg::CTRL_COMBO_BIT] && sel.low |-> cmd_freq == preset_mem[2])
      else $error("low select did not take priority");
   AST_ACCEL_STEP: assert property (
      freq_reg < target && $stable(target) |=> freq_reg <= $past(freq_reg) + 16'h0001
      || $past(rate) == 24'h000000)
      else $error("acceleration step larger than one unit");
   AST_DECEL_ZERO: assert property (
      state_reg == drive_cmd_pkg::RUN_FWD && !req.fwd && freq_reg == 16'h0000
      |=> state_reg == drive_cmd_pkg::RUN_STOP)
      else $error("stop not reached at zero frequency");
   AST_FWD_LIT: assert property (
      state_reg == drive_cmd_pkg::RUN_FWD && run_req && cmd_freq != 16'h0000
      |=> RUN_INDICATOR)
      else $error("run indicator not lit in forward rotation");
   AST_OFF_STOPPED: assert property (
      state_reg == drive_cmd_pkg::RUN_STOP ##1 state_reg == drive_cmd_pkg::RUN_STOP
      |-> !RUN_INDICATOR)
      else $error("run indicator on while stopped");
   AST_CUR_SCALE: assert property (
      req.cur_sel && !(|sel) && CUR_IN <= drive_cmd_pkg::CUR_ZERO_CODE
      |-> cmd_freq == current_bias_freq)
      else $error("current below zero point did not command bias frequency");
   AST_VOLT_FULL: assert property (
      !req.cur_sel && !(|sel) && ctrl_reg[drive_cmd_pkg::CTRL_VREF_BIT]
      && VOLT_IN == drive_cmd_pkg::ADC_FULL |-> cmd_freq == voltage_gain_freq)
      else $error("full voltage did not command gain frequency");
   AST_ACK_BLINK: assert property (
      WR |=> ack_ms_reg == 12'(drive_cmd_pkg::ACK_BLINK_MS))
      else $error("acknowledge window not started by a write");
   AST_NO_REF_ZERO: assert property (
      !(|sel) && !req.cur_sel && !ctrl_reg[drive_cmd_pkg::CTRL_VREF_BIT]
      |-> cmd_freq == 16'h0000)
      else $error("command nonzero without any reference");

   COV_FWD_RUN: cover property (state_reg == drive_cmd_pkg::RUN_FWD && freq_reg == target
                                && target != 16'h0000);
   COV_REV_RUN: cover property (state_reg == drive_cmd_pkg::RUN_REV && freq_reg != 16'h0000);
   COV_BOTH_STOP: cover property (req.fwd && req.rev && freq_reg != 16'h0000);
   COV_CUR_REF: cover property (req.cur_sel && cmd_freq == current_gain_freq);

endmodule : drive_speed_command_select
